// *** ccpu_unit.sv ***
// Compare/PWM pin unit: APB registers, 16-bit compare against
// timer_one, pin actions, special event trigger, standard PWM.
// Assumes one clock pclk and adc_enabled from logic on pclk.
// Function
// - Compare pair against timer_one every cycle
// - A new match in a compare mode sets the event flag
// - Zero control write clears compare latch
// - Mode 1010 only flags, pin untouched
// - Mode 1011 resets timer, starts conversion
// - Trigger asserted in the match cycle
// - Timer clears at next timer edge
// - Compare pair acts as timer period
// - Special reset sets no overflow flag
// - Match removed before reset skips it
// - No compare while the clock sleeps
// - Pin relocatable by alternate select
// - PWM with up to 10-bit resolution
// - Period, control and duty shape PWM
// - High for pulse, 0% low, 100% high
// - Zero control write releases the pin
`timescale 1ns/1ps
module ccpu_unit (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter
    input  wire logic        adc_enabled,
    output logic             adc_start,
    output logic             special_event_trigger,
    // Pins: index 0 primary, 1 alternate
    output logic [1:0]       pin_out,
    output logic [1:0]       pin_oe_n
);
    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == ccpu_pkg::MODE_PWM_TOP;
    endfunction : is_pwm

    function automatic logic is_cmp(input logic [3:0] m);
        return m == ccpu_pkg::MODE_TOGGLE || m == ccpu_pkg::MODE_SET ||
               m == ccpu_pkg::MODE_CLEAR || m == ccpu_pkg::MODE_SWINT ||
               m == ccpu_pkg::MODE_SPECIAL;
    endfunction : is_cmp

    function automatic logic drives_pin(input logic [3:0] m);
        return m == ccpu_pkg::MODE_TOGGLE || m == ccpu_pkg::MODE_SET ||
               m == ccpu_pkg::MODE_CLEAR || is_pwm(m);
    endfunction : drives_pin

    // Register state
    logic [7:0]  ctrl;
    logic [15:0] cmp;
    logic [7:0]  irq_en;
    logic        evt_flag;
    logic        ovf_flag;
    logic [7:0]  t1_cfg;
    logic        alt_sel;
    logic [7:0]  period;
    logic [7:0]  t2_ctrl;
    logic [7:0]  next_ctrl;
    logic [15:0] next_cmp;
    logic [7:0]  next_irq_en;
    logic        next_evt_flag;
    logic        next_ovf_flag;
    logic [7:0]  next_t1_cfg;
    logic        next_alt_sel;
    logic [7:0]  next_period;
    logic [7:0]  next_t2_ctrl;
    // Bus state
    logic        wr;
    logic        rd_load;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        mapped;
    // Compare state
    logic        match;
    logic        cmp_latch;
    logic        next_match;
    logic        next_cmp_latch;
    logic        next_trig;
    logic        next_adc;
    logic        evt_set;
    logic [3:0]  mode;
    logic [3:0]  next_mode;
    logic [1:0]  next_pin_out;
    logic [1:0]  next_pin_oe_n;
    logic        pin_val;
    // Timer and PWM links
    logic [15:0] t1_count;
    logic [15:0] t1_next;
    logic        t1_ovf;
    logic        t1_load;
    logic        t1_clr;
    logic        pwm_out;
    logic [9:0]  duty_latch;

    assign mode = ctrl[ccpu_pkg::CTRL_MODE_LSB +: 4];
    assign wr = psel && penable && pready && pwrite;
    assign rd_load = psel && penable && !pready;
    assign t1_load = wr && paddr == ccpu_pkg::OFS_T1_COUNT;
    // Live equality; a rewritten pair drops the pending reset
    assign t1_clr = mode == ccpu_pkg::MODE_SPECIAL && t1_count == cmp;

    ccpu_timer_one #(
        .W (16)
    ) u_timer_one (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (t1_cfg[ccpu_pkg::T1_ON_BIT]),
        .ps_sel     (t1_cfg[ccpu_pkg::T1_PS_LSB +: 2]),
        .load       (t1_load),
        .load_val   (pwdata[15:0]),
        .clr        (t1_clr),
        .count      (t1_count),
        .next_count (t1_next),
        .ovf        (t1_ovf)
    );

    ccpu_pwm u_pwm (
        .pclk       (pclk),
        .presetn    (presetn),
        .enable     (is_pwm(mode)),
        .t2_on      (t2_ctrl[ccpu_pkg::T2_ON_BIT]),
        .t2_ps      (t2_ctrl[ccpu_pkg::T2_PS_LSB +: 2]),
        .period     (period),
        .duty       ({cmp[7:0], ctrl[ccpu_pkg::CTRL_DUTY_LSB +: 2]}),
        .pwm_out    (pwm_out),
        .duty_latch (duty_latch)
    );

    // Register writes; hardware set wins over software clear
    always_comb begin
        next_ctrl = ctrl;
        next_cmp = cmp;
        next_irq_en = irq_en;
        next_evt_flag = evt_flag;
        next_ovf_flag = ovf_flag;
        next_t1_cfg = t1_cfg;
        next_alt_sel = alt_sel;
        next_period = period;
        next_t2_ctrl = t2_ctrl;
        if (wr) begin
            if (paddr == ccpu_pkg::OFS_CONTROL) begin
                next_ctrl = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_CMP_LOW) begin
                next_cmp[7:0] = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_CMP_HIGH && !is_pwm(mode)) begin
                // High byte is read-only while PWM owns it
                next_cmp[15:8] = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_IRQ_EN) begin
                next_irq_en = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_IRQ_FLAGS) begin
                next_evt_flag = pwdata[ccpu_pkg::FLAG_EVT_BIT];
                next_ovf_flag = pwdata[ccpu_pkg::FLAG_OVF_BIT];
            end else if (paddr == ccpu_pkg::OFS_T1_CONFIG) begin
                next_t1_cfg = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_ALT_PIN) begin
                next_alt_sel = pwdata[0];
            end else if (paddr == ccpu_pkg::OFS_PERIOD) begin
                next_period = pwdata[7:0];
            end else if (paddr == ccpu_pkg::OFS_T2_CTRL) begin
                next_t2_ctrl = pwdata[7:0];
            end
        end
        next_mode = next_ctrl[ccpu_pkg::CTRL_MODE_LSB +: 4];
        // Equality judged on the values that the coming edge installs
        next_match = (t1_next == next_cmp);
        evt_set = next_match && !match && is_cmp(next_mode);
        if (evt_set) begin
            next_evt_flag = 1'b1;
        end
        if (t1_ovf) begin
            next_ovf_flag = 1'b1;
        end
    end

    // Compare latch, trigger, conversion start and pin control
    always_comb begin
        next_cmp_latch = cmp_latch;
        if (wr && paddr == ccpu_pkg::OFS_CONTROL && pwdata[7:0] == 8'h00) begin
            next_cmp_latch = 1'b0;
        end else if (evt_set) begin
            case (next_mode)
                ccpu_pkg::MODE_SET:    next_cmp_latch = 1'b1;
                ccpu_pkg::MODE_CLEAR:  next_cmp_latch = 1'b0;
                ccpu_pkg::MODE_TOGGLE: next_cmp_latch = !cmp_latch;
                default:               next_cmp_latch = cmp_latch;
            endcase
        end
        next_trig = next_mode == ccpu_pkg::MODE_SPECIAL && next_match;
        next_adc = next_trig && !special_event_trigger && adc_enabled;
        pin_val = is_pwm(next_mode) ? pwm_out : next_cmp_latch;
        next_pin_out = 2'h0;
        next_pin_oe_n = 2'h3;
        // Modes 1010, 1011 and off leave the pin to the port
        if (drives_pin(next_mode)) begin
            next_pin_out[alt_sel] = pin_val;
            next_pin_oe_n[alt_sel] = 1'b0;
        end
    end

    // Read data and answer; one wait state per access
    always_comb begin
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        if (paddr == ccpu_pkg::OFS_CONTROL) begin
            next_prdata[7:0] = ctrl;
        end else if (paddr == ccpu_pkg::OFS_CMP_LOW) begin
            next_prdata[7:0] = cmp[7:0];
        end else if (paddr == ccpu_pkg::OFS_CMP_HIGH) begin
            next_prdata[7:0] = is_pwm(mode) ? duty_latch[9:2] : cmp[15:8];
        end else if (paddr == ccpu_pkg::OFS_IRQ_EN) begin
            next_prdata[7:0] = irq_en;
        end else if (paddr == ccpu_pkg::OFS_IRQ_FLAGS) begin
            next_prdata[ccpu_pkg::FLAG_EVT_BIT] = evt_flag;
            next_prdata[ccpu_pkg::FLAG_OVF_BIT] = ovf_flag;
        end else if (paddr == ccpu_pkg::OFS_T1_COUNT) begin
            next_prdata[15:0] = t1_count;
        end else if (paddr == ccpu_pkg::OFS_T1_CONFIG) begin
            next_prdata[7:0] = t1_cfg;
        end else if (paddr == ccpu_pkg::OFS_ALT_PIN) begin
            next_prdata[0] = alt_sel;
        end else if (paddr == ccpu_pkg::OFS_PERIOD) begin
            next_prdata[7:0] = period;
        end else if (paddr == ccpu_pkg::OFS_T2_CTRL) begin
            next_prdata[7:0] = t2_ctrl;
        end else begin
            mapped = 1'b0;
        end
        next_pready = rd_load;
        next_pslverr = rd_load && !mapped;
        if (!rd_load) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ccpu_pkg::RST_BYTE;
            cmp <= ccpu_pkg::RST_CMP;
            irq_en <= ccpu_pkg::RST_BYTE;
            evt_flag <= 1'b0;
            ovf_flag <= 1'b0;
            t1_cfg <= ccpu_pkg::RST_BYTE;
            alt_sel <= 1'b0;
            period <= ccpu_pkg::RST_PERIOD;
            t2_ctrl <= ccpu_pkg::RST_BYTE;
            match <= 1'b1;
            cmp_latch <= 1'b0;
            special_event_trigger <= 1'b0;
            adc_start <= 1'b0;
            pin_out <= 2'h0;
            pin_oe_n <= 2'h3;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            cmp <= next_cmp;
            irq_en <= next_irq_en;
            evt_flag <= next_evt_flag;
            ovf_flag <= next_ovf_flag;
            t1_cfg <= next_t1_cfg;
            alt_sel <= next_alt_sel;
            period <= next_period;
            t2_ctrl <= next_t2_ctrl;
            match <= next_match;
            cmp_latch <= next_cmp_latch;
            special_event_trigger <= next_trig;
            adc_start <= next_adc;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_zero_ctrl;
        wr && paddr == ccpu_pkg::OFS_CONTROL && pwdata[7:0] == 8'h00;
    endsequence
    sequence s_special_reset;
        special_event_trigger && t1_clr && u_timer_one.tick && !t1_load;
    endsequence

    property p_trig_equal;
        special_event_trigger == (mode == ccpu_pkg::MODE_SPECIAL && t1_count == cmp);
    endproperty
    a_trig_equal: assert property (p_trig_equal)
        else $error("trigger not equal to live match");

    property p_flag_on_match;
        (is_cmp(mode) && t1_count == cmp && !$past(t1_count == cmp)) |-> evt_flag;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match)
        else $error("match did not set event flag");

    property p_zero_latch;
        s_zero_ctrl |=> !cmp_latch;
    endproperty
    a_zero_latch: assert property (p_zero_latch)
        else $error("compare latch not cleared");

    property p_swint_no_pin;
        mode == ccpu_pkg::MODE_SWINT && $past(mode == ccpu_pkg::MODE_SWINT) |-> pin_oe_n == 2'h3;
    endproperty
    a_swint_no_pin: assert property (p_swint_no_pin)
        else $error("pin driven in interrupt-only mode");

    property p_special_reset;
        s_special_reset |=> t1_count == 16'h0000 && !$rose(ovf_flag);
    endproperty
    a_special_reset: assert property (p_special_reset)
        else $error("timer not reset or overflow flagged");

    property p_adc_pulse;
        adc_start |=> !adc_start;
    endproperty
    a_adc_pulse: assert property (p_adc_pulse)
        else $error("conversion start wider than one cycle");

    property p_adc_cause;
        adc_start |-> special_event_trigger && !$past(special_event_trigger);
    endproperty
    a_adc_cause: assert property (p_adc_cause)
        else $error("conversion start without new trigger");

    property p_release;
        s_zero_ctrl ##1 (mode == ccpu_pkg::MODE_OFF) |=> pin_oe_n == 2'h3;
    endproperty
    a_release: assert property (p_release)
        else $error("pin not released after zero control");

    property p_alt_only;
        pin_oe_n != 2'h3 |-> !pin_oe_n[!$past(alt_sel)] == 1'b0;
    endproperty
    a_alt_only: assert property (p_alt_only)
        else $error("unselected pin location driven");
endmodule : ccpu_unit

// *** ccpu_pkg.sv ***
// Package: register map, field layout, reset values and mode codes
// of the compare/PWM pin unit.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
package ccpu_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_CMP_LOW   = 8'h04;
    localparam logic [7:0] OFS_CMP_HIGH  = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h10;
    localparam logic [7:0] OFS_T1_COUNT  = 8'h14;
    localparam logic [7:0] OFS_T1_CONFIG = 8'h18;
    localparam logic [7:0] OFS_ALT_PIN   = 8'h1c;
    localparam logic [7:0] OFS_PERIOD    = 8'h20;
    localparam logic [7:0] OFS_T2_CTRL   = 8'h24;
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUTY_LSB = 4;
    localparam int FLAG_OVF_BIT  = 0;
    localparam int FLAG_EVT_BIT  = 2;
    localparam int T1_ON_BIT     = 0;
    localparam int T1_PS_LSB     = 4;
    localparam int T2_PS_LSB     = 0;
    localparam int T2_ON_BIT     = 2;
    // Reset values
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_CMP    = 16'h0000;
    localparam logic [7:0]  RST_PERIOD = 8'hff;
    // Mode select codes
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_TOGGLE  = 4'h2;
    localparam logic [3:0] MODE_SET     = 4'h8;
    localparam logic [3:0] MODE_CLEAR   = 4'h9;
    localparam logic [3:0] MODE_SWINT   = 4'ha;
    localparam logic [3:0] MODE_SPECIAL = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
endpackage : ccpu_pkg

// *** ccpu_timer_one.sv ***
// timer_one: 16-bit up counter with prescaler, load and special reset.
// Assumes load and clear come from logic on pclk.
`timescale 1ns/1ps
module ccpu_timer_one #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         run,
    input  wire logic [1:0]   ps_sel,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         clr,
    // Status
    output logic [W-1:0]      count,
    output logic [W-1:0]      next_count,
    output logic              ovf
);
    logic [2:0] pcnt;
    logic [2:0] next_pcnt;
    logic [2:0] last;
    logic       tick;

    always_comb begin
        last = 3'h7 >> (2'h3 - ps_sel);
        tick = run && (pcnt == last);
        next_pcnt = (!run || tick) ? 3'h0 : pcnt + 3'h1;
        next_count = count;
        ovf = 1'b0;
        if (load) begin
            next_count = load_val;
        end else if (tick && clr) begin
            // Special reset waits for a timer edge; no overflow from it
            next_count = '0;
        end else if (tick) begin
            next_count = count + 1'b1;
            ovf = (count == {W{1'b1}});
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt <= 3'h0;
            count <= '0;
        end else begin
            pcnt <= next_pcnt;
            count <= next_count;
        end
    end
endmodule : ccpu_timer_one

// *** ccpu_pwm.sv ***
// Standard PWM: 8-bit period timer widened to a 10-bit time base,
// double-buffered 10-bit duty. Assumes controls are on pclk.
`timescale 1ns/1ps
module ccpu_pwm (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       enable,
    input  wire logic       t2_on,
    input  wire logic [1:0] t2_ps,
    input  wire logic [7:0] period,
    input  wire logic [9:0] duty,
    // Status
    output logic            pwm_out,
    output logic [9:0]      duty_latch
);
    logic [3:0] pcnt;
    logic [3:0] next_pcnt;
    logic [3:0] last;
    logic       step;
    logic [9:0] base;
    logic [9:0] next_base;
    logic [9:0] next_latch;
    logic       next_out;

    always_comb begin
        last = (t2_ps == 2'h0) ? 4'h0 : ((t2_ps == 2'h1) ? 4'h3 : 4'hf);
        step = enable && t2_on && (pcnt == last);
        next_pcnt = step || !enable ? 4'h0 : pcnt + 4'h1;
        next_base = base;
        next_latch = duty_latch;
        next_out = pwm_out;
        if (!enable) begin
            next_base = 10'h000;
            next_latch = duty;
            next_out = 1'b0;
        end else if (step && base == {period, 2'h3}) begin
            // Period end: restart, latch duty, set unless 0%
            next_base = 10'h000;
            next_latch = duty;
            next_out = (duty != 10'h000);
        end else if (step) begin
            next_base = base + 10'h001;
            // Duty beyond the period never matches: stays high
            if (next_base == duty_latch) begin
                next_out = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt <= 4'h0;
            base <= 10'h000;
            duty_latch <= 10'h000;
            pwm_out <= 1'b0;
        end else begin
            pcnt <= next_pcnt;
            base <= next_base;
            duty_latch <= next_latch;
            pwm_out <= next_out;
        end
    end
endmodule : ccpu_pwm

// *** ccpu_load_model.sv ***
// Load model: the external load hanging on the unit's primary pin.
// Assumes pin_oe_n low means the unit drives that pin location.
`timescale 1ns/1ps
module ccpu_load_model (
    // Clock
    input  wire logic       pclk,
    // Pins
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe_n,
    // Measurement window
    input  wire logic       en,
    output logic [7:0]      high_cnt
);
    // Pull-down: a released pin reads low
    wire logic level = !pin_oe_n[0] && pin_out[0];

    always @(posedge pclk)
        if (!en)
            high_cnt <= 8'h00;
        else if (level)
            high_cnt <= high_cnt + 8'h01;
endmodule : ccpu_load_model

// *** ccpu_unit_tb.sv ***
// Testbench: APB master, compare and trigger checks, PWM via load model.
// Assumes the unit's one-wait-state APB and registered pins.
`timescale 1ns/1ps
module ccpu_unit_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic        adc_enabled = 1'b0;
    logic        en = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        adc_start;
    logic        special_event_trigger;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe_n;
    logic [7:0]  high_cnt;
    logic [31:0] rd;
    logic [31:0] seed = 32'h00011399;
    logic [33:0] q[$];
    logic [33:0] note;
    logic        sel;
    logic [3:0]  modes [6] = '{4'h8, 4'h9, 4'h2, 4'h0, 4'h2, 4'ha};
    logic [5:0]  drv = 6'b010111;
    logic [5:0]  val = 6'b010101;
    logic [5:0]  flg = 6'b110111;
    logic [7:0]  dl [3] = '{8'h00, 8'h01, 8'hff};
    logic [1:0]  dc [3] = '{2'h0, 2'h2, 2'h3};
    int          hi [3] = '{0, 12, 32};
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;

    always #5 pclk = ~pclk;

    ccpu_unit i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_enabled(adc_enabled),
        .adc_start(adc_start), .special_event_trigger(special_event_trigger),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));

    ccpu_load_model i_load (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .en(en), .high_cnt(high_cnt));

    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // Extra idle edge at the end keeps psel from two drives in one step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic err, input logic chk, input logic [31:0] exp);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        q.push_back({chk, err, exp});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0, 1'b1, exp);
    endtask : rdc

    task wait_trig;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (special_event_trigger !== 1'b1 && n < 300);
        if (n >= 300)
            check(32'h0, 32'h1);
    endtask : wait_trig

    // Result watcher: oldest note against each completed transfer
    always @(posedge pclk)
        if (pready === 1'b1 && q.size() > 0) begin
            note = q.pop_front();
            check({31'h0, pslverr}, {31'h0, note[32]});
            if (note[33])
                check(prdata, note[31:0]);
        end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results;
        end
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 10; i++)
            rdc(8'(i * 4), (i == 8) ? {24'h0, ccpu_pkg::RST_PERIOD} : 32'h0);
        apb(1'b0, 8'h28, 32'h0, 1'b1, 1'b1, 32'h0);
        apb(1'b1, 8'h28, 32'h5a, 1'b1, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(i[0] ? ccpu_pkg::OFS_CMP_HIGH : ccpu_pkg::OFS_CMP_LOW, seed);
            rdc(i[0] ? ccpu_pkg::OFS_CMP_HIGH : ccpu_pkg::OFS_CMP_LOW,
                {24'h0, seed[7:0]});
        end
        // Special event trigger, period 0x21 counts
        wr(ccpu_pkg::OFS_CMP_LOW, 32'h20);
        wr(ccpu_pkg::OFS_CMP_HIGH, 32'h0);
        adc_enabled <= 1'b1;
        wr(ccpu_pkg::OFS_CONTROL, {28'h0, ccpu_pkg::MODE_SPECIAL});
        wr(ccpu_pkg::OFS_T1_CONFIG, 32'h1);
        wait_trig;
        for (int k = 0; k < 2; k++) begin
            check({31'h0, adc_start}, {31'h0, adc_enabled});
            check({30'h0, pin_oe_n}, 32'h3);
            @(posedge pclk);
            adc_enabled <= 1'b0;
            @(negedge pclk);
            check({30'h0, special_event_trigger, adc_start}, 32'h0);
            if (k == 0) begin
                wait_trig;
                check(n, 32);
            end
        end
        @(posedge pclk);
        rdc(ccpu_pkg::OFS_IRQ_FLAGS, 32'h4);
        wr(ccpu_pkg::OFS_IRQ_FLAGS, 32'h0);
        // Slow timer: move the compare away before the reset tick
        wr(ccpu_pkg::OFS_T1_CONFIG, 32'h31);
        wait_trig;
        @(posedge pclk);
        wr(ccpu_pkg::OFS_CMP_LOW, 32'h40);
        repeat (16) @(posedge pclk);
        apb(1'b0, ccpu_pkg::OFS_T1_COUNT, 32'h0, 1'b0, 1'b0, 32'h0);
        check({31'h0, rd[15:0] > 16'h20}, 32'h1);
        // Drop the flag left by the trigger runs, else mode checks see it
        wr(ccpu_pkg::OFS_IRQ_FLAGS, 32'h0);
        wr(ccpu_pkg::OFS_T1_CONFIG, 32'h1);
        // Pin actions per mode; entry 3 is the full zero write
        for (int i = 0; i < 6; i++) begin
            sel = (i == 1);
            wr(ccpu_pkg::OFS_ALT_PIN, {31'h0, sel});
            wr(ccpu_pkg::OFS_CONTROL, {28'h0, modes[i]});
            wr(ccpu_pkg::OFS_T1_COUNT, 32'h3c);
            repeat (10) @(posedge pclk);
            check({30'h0, pin_oe_n},
                  drv[i] ? (sel ? 32'h1 : 32'h2) : 32'h3);
            if (drv[i])
                check({31'h0, pin_out[sel]}, {31'h0, val[i]});
            rdc(ccpu_pkg::OFS_IRQ_FLAGS, {29'h0, flg[i], 2'h0});
            wr(ccpu_pkg::OFS_IRQ_FLAGS, 32'h0);
        end
        // PWM: 16 steps a period, counted over two periods
        wr(ccpu_pkg::OFS_PERIOD, 32'h3);
        wr(ccpu_pkg::OFS_T2_CTRL, 32'h4);
        for (int j = 0; j < 3; j++) begin
            wr(ccpu_pkg::OFS_CMP_LOW, {24'h0, dl[j]});
            wr(ccpu_pkg::OFS_CONTROL, {26'h0, dc[j], 4'hc});
            repeat (40) @(posedge pclk);
            en <= 1'b1;
            repeat (32) @(posedge pclk);
            en <= 1'b0;
            @(posedge pclk);
            check({24'h0, high_cnt}, hi[j]);
            check({30'h0, pin_oe_n}, 32'h2);
        end
        wr(ccpu_pkg::OFS_CONTROL, 32'h0);
        repeat (2) @(posedge pclk);
        check({30'h0, pin_oe_n}, 32'h3);
        results;
    end
endmodule : ccpu_unit_tb
